// ---- host_power_model.sv ----
/*
  Host-side model of the sensor supply and reset pins.
  Assumes pins move in the core_clk domain and rst clears every pin.
*/
`timescale 1ns/1ps
module host_power_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pwr_on,
  output logic supply_good,
  output logic shutdown_n,
  output logic powerdown_n
);
  // ****************************************
  // Pin sequencing
  // ****************************************
  // 2 ms of 50 ns cycles
  localparam logic [15:0] HOLD_LOW = 16'h9C40;
  logic supply_q;
  logic supply_d;
  logic shut_q;
  logic shut_d;
  logic [15:0] low_q;
  logic [15:0] low_d;
  always_comb begin
    // One flag stands for all rails, so core rises with the last of them
    supply_d = pwr_on | shut_q;
    // Pin only rises after a full minimum-width low pulse
    shut_d = pwr_on & supply_q & (shut_q | (low_q >= HOLD_LOW));
    low_d = low_q;
    if (shut_q) begin
      low_d = 16'h0000;
    end else if (low_q < HOLD_LOW) begin
      low_d = low_q + 16'h0001;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      supply_q <= 1'h0;
      shut_q <= 1'h0;
      low_q <= 16'h0000;
    end else begin
      supply_q <= supply_d;
      shut_q <= shut_d;
      low_q <= low_d;
    end
  end
  assign supply_good = supply_q;
  assign shutdown_n = shut_q;
  // Tied to the io rail so only shutdown_n has its own sequencing
  assign powerdown_n = supply_q;
endmodule // host_power_model

// ---- sensor_power_reset_sequencer.sv ----
/*
  Sensor-side power-up reset, PLL lock, streaming start and standby entry sequencer.
  Assumes supply-good, reset pins and software requests arrive synchronous to core_clk.
*/
// Summary of operation
// - PLL locks within 0.2 ms
// - First frame within 10 ms plus exposure
// - Standby waits for frame end, else immediate
// - Internal logic reset at power-up
// - Reset pin active low, acts at once
// - 10-bit, four lanes, 30/60 fps formats
`timescale 1ns/1ps
module sensor_power_reset_sequencer #(
  parameter int unsigned FIRST_FIXED = sensor_seq_pkg::FIRST_FIXED_CYCLES,
  parameter int unsigned FRAME30 = sensor_seq_pkg::FRAME30_CYCLES,
  parameter int unsigned FRAME60 = sensor_seq_pkg::FRAME60_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic supply_good,
  input wire logic shutdown_n,
  input wire logic powerdown_n,
  input wire logic stream_req,
  input wire logic standby_req,
  input wire logic [2:0] fmt_sel,
  input wire logic [15:0] exposure_lines,
  output sensor_seq_pkg::seq_status_t status,
  output sensor_seq_pkg::frame_size_t frame_size
);

  // ****************************************
  // State
  // ****************************************
  sensor_seq_pkg::seq_state_t state_q, state_d;
  sensor_seq_pkg::seq_status_t stat_q, stat_d;
  sensor_seq_pkg::frame_size_t size_q, size_d;
  logic [23:0] cnt_q, cnt_d;
  logic [23:0] cnt_dec;
  logic [23:0] period;
  logic [23:0] expo_cycles;
  logic power_bad;

  assign power_bad = !supply_good || !shutdown_n || !powerdown_n;
  assign cnt_dec = cnt_q - 24'h000001;
  assign period = stat_q.fps60 ? 24'(FRAME60 - 1) : 24'(FRAME30 - 1);
  assign expo_cycles = 24'(exposure_lines * sensor_seq_pkg::LINE_CYCLES);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    state_d = state_q;
    stat_d = stat_q;
    size_d = size_q;
    cnt_d = cnt_q;
    stat_d.frame_start = 1'b0;
    if (power_bad) begin
      // Any pin or supply drop resets state, counter and status but keeps frame_size, no clock count needed
      state_d = sensor_seq_pkg::ST_OFF;
      cnt_d = 24'(sensor_seq_pkg::POR_CYCLES - 1);
      stat_d = '0;
      stat_d.int_reset = 1'b1;
    end else begin
      case (state_q)
        sensor_seq_pkg::ST_OFF: begin
          stat_d.int_reset = 1'b1;
          if (cnt_q == 24'h000000) begin
            state_d = sensor_seq_pkg::ST_PLL;
            cnt_d = 24'(sensor_seq_pkg::PLL_LOCK_CYCLES - 1);
            stat_d.int_reset = 1'b0;
          end else begin
            cnt_d = cnt_dec;
          end
        end
        sensor_seq_pkg::ST_PLL: begin
          if (cnt_q == 24'h000000) begin
            state_d = sensor_seq_pkg::ST_STBY;
            stat_d.pll_locked = 1'b1;
            stat_d.standby = 1'b1;
          end else begin
            cnt_d = cnt_dec;
          end
        end
        sensor_seq_pkg::ST_STBY: begin
          if (stream_req && !standby_req) begin
            state_d = sensor_seq_pkg::ST_FIXW;
            cnt_d = 24'(FIRST_FIXED - 1);
            stat_d.standby = 1'b0;
            stat_d.streaming = 1'b1;
            stat_d.fps60 = sensor_seq_pkg::fmt_binned(fmt_sel);
            size_d = sensor_seq_pkg::fmt_size(fmt_sel);
          end
        end
        sensor_seq_pkg::ST_FIXW, sensor_seq_pkg::ST_EXPW: begin
          if (standby_req) begin
            // No frame is out yet, so standby is immediate
            state_d = sensor_seq_pkg::ST_STBY;
            stat_d.standby = 1'b1;
            stat_d.streaming = 1'b0;
          end else if (cnt_q != 24'h000000) begin
            cnt_d = cnt_dec;
          end else if (state_q == sensor_seq_pkg::ST_FIXW && expo_cycles != 24'h000000) begin
            state_d = sensor_seq_pkg::ST_EXPW;
            cnt_d = expo_cycles - 24'h000001;
          end else begin
            state_d = sensor_seq_pkg::ST_STRM;
            cnt_d = period;
            stat_d.frame_start = 1'b1;
            stat_d.frame_active = 1'b1;
          end
        end
        sensor_seq_pkg::ST_STRM: begin
          if (standby_req && !stat_q.frame_active) begin
            state_d = sensor_seq_pkg::ST_STBY;
            stat_d.standby = 1'b1;
            stat_d.streaming = 1'b0;
          end else if (cnt_q == 24'h000000) begin
            if (standby_req) begin
              state_d = sensor_seq_pkg::ST_STBY;
              stat_d.standby = 1'b1;
              stat_d.streaming = 1'b0;
            end else begin
              cnt_d = period;
              stat_d.frame_start = 1'b1;
              stat_d.frame_active = 1'b1;
            end
          end else begin
            cnt_d = cnt_dec;
            stat_d.frame_active = cnt_dec >= sensor_seq_pkg::BLANK_CYCLES;
            if (standby_req) begin
              // Frame in flight: finish it before standby
              state_d = sensor_seq_pkg::ST_STOP;
            end
          end
        end
        sensor_seq_pkg::ST_STOP: begin
          cnt_d = cnt_dec;
          stat_d.frame_active = cnt_dec >= sensor_seq_pkg::BLANK_CYCLES;
          if (!stat_d.frame_active || cnt_q == 24'h000000) begin
            state_d = sensor_seq_pkg::ST_STBY;
            stat_d.frame_active = 1'b0;
            stat_d.standby = 1'b1;
            stat_d.streaming = 1'b0;
          end
        end
        default: begin
          state_d = sensor_seq_pkg::ST_OFF;
          cnt_d = 24'(sensor_seq_pkg::POR_CYCLES - 1);
          stat_d = '0;
          stat_d.int_reset = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= sensor_seq_pkg::ST_OFF;
      stat_q <= 7'h40;
      size_q <= 24'h000000;
      cnt_q <= 24'(sensor_seq_pkg::POR_CYCLES - 1);
    end else begin
      state_q <= state_d;
      stat_q <= stat_d;
      size_q <= size_d;
      cnt_q <= cnt_d;
    end
  end

  assign status = stat_q;
  assign frame_size = size_q;

  // ****************************************
  // Checks
  // ****************************************
  logic [24:0] wait_q, wait_d;
  always_comb begin
    wait_d = 25'h0000000;
    if (state_q == sensor_seq_pkg::ST_FIXW || state_q == sensor_seq_pkg::ST_EXPW) begin
      wait_d = wait_q + 25'h0000001;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wait_q <= 25'h0000000;
    end else begin
      wait_q <= wait_d;
    end
  end

  // Cycles out of reset without lock; a long delay range would be costly to unroll
  logic [15:0] lock_wait_q, lock_wait_d;
  always_comb begin
    lock_wait_d = 16'h0000;
    if (!stat_q.int_reset && !stat_q.pll_locked) begin
      lock_wait_d = (lock_wait_q == 16'hFFFF) ? lock_wait_q : lock_wait_q + 16'h0001;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lock_wait_q <= 16'h0000;
    end else begin
      lock_wait_q <= lock_wait_d;
    end
  end

  power_reset_a: assert property (@(posedge core_clk) disable iff (rst)
    power_bad |=> stat_q.int_reset && !stat_q.pll_locked)
    else $error("internal reset not held on power loss");
  pin_reset_a: assert property (@(posedge core_clk) disable iff (rst)
    !shutdown_n |=> !stat_q.streaming && !stat_q.frame_active)
    else $error("shutdown pin did not stop the sensor");
  pll_lock_a: assert property (@(posedge core_clk) disable iff (rst)
    lock_wait_q <= 16'(sensor_seq_pkg::PLL_LOCK_CYCLES))
    else $error("PLL not locked in time");
  first_frame_a: assert property (@(posedge core_clk) disable iff (rst)
    wait_q <= 25'(FIRST_FIXED) + 25'(expo_cycles))
    else $error("first frame start too late");
  standby_idle_a: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == sensor_seq_pkg::ST_STRM && standby_req && !stat_q.frame_active && !power_bad)
    |=> stat_q.standby && !stat_q.streaming)
    else $error("idle standby not immediate");
  standby_wait_a: assert property (@(posedge core_clk) disable iff (rst)
    stat_q.frame_active |-> !stat_q.standby)
    else $error("standby entered mid frame");
  frame_start_a: assert property (@(posedge core_clk) disable iff (rst)
    stat_q.frame_start |-> stat_q.frame_active && stat_q.streaming && !$past(stat_q.frame_active))
    else $error("frame start without active frame");
  frame_rate_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(stat_q.streaming) |-> stat_q.fps60 == sensor_seq_pkg::fmt_binned($past(fmt_sel)))
    else $error("frame rate does not match format");

endmodule // sensor_power_reset_sequencer

// ---- sensor_power_reset_sequencer_test.sv ----
/*
  Self-checking bench for the sensor power and reset sequencer.
  Assumes the host pin model is compiled first; frame counts are shortened.
*/
`timescale 1ns/1ps
module sensor_power_reset_sequencer_test;
  // ****************************************
  // Signals and instances
  // ****************************************
  localparam int FF = 200;
  localparam int INTR = 6;
  localparam int LOCK = 5;
  localparam int STBY = 4;
  localparam int SOF = 1;
  localparam int ACT = 2;
  localparam int BUS_GAP = 8192;
  logic core_clk;
  logic rst;
  logic pwr_on;
  logic supply_good;
  logic shutdown_n;
  logic powerdown_n;
  logic stream_req;
  logic standby_req;
  logic [2:0] fmt_sel;
  logic [15:0] exposure_lines;
  sensor_seq_pkg::seq_status_t status;
  sensor_seq_pkg::frame_size_t frame_size;
  int err_total;
  int samples_checked;
  int n;
  logic [23:0] size_tab [5] = '{24'hCC0990, 24'hCC072C, 24'hB00630, 24'h6604C8, 24'h580318};

  host_power_model host (.core_clk(core_clk), .rst(rst), .pwr_on(pwr_on),
    .supply_good(supply_good), .shutdown_n(shutdown_n), .powerdown_n(powerdown_n));

  sensor_power_reset_sequencer #(.FIRST_FIXED(FF), .FRAME30(4000), .FRAME60(2000)) DUT (
    .core_clk(core_clk), .rst(rst), .supply_good(supply_good), .shutdown_n(shutdown_n),
    .powerdown_n(powerdown_n), .stream_req(stream_req), .standby_req(standby_req),
    .fmt_sel(fmt_sel), .exposure_lines(exposure_lines), .status(status),
    .frame_size(frame_size));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t ns: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask

  task automatic step();
    @(posedge core_clk);
    #1;
  endtask

  // Bounded wait on one status bit; n holds cycles waited
  task automatic wait_bit(input int b, input logic v, input int lim);
    n = 0;
    while (status[b] !== v && n < lim) begin
      step();
      n++;
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic power_up();
    check(status, 7'h40);
    check(frame_size, 24'h0);
    pwr_on <= 1'h1;
    n = 0;
    while (shutdown_n !== 1'h1 && n < 40100) begin
      step();
      n++;
    end
    check(n >= 39999, 1'h1);
    wait_bit(INTR, 1'h0, 40);
    check(n >= 15 && n <= 18, 1'h1);
    wait_bit(LOCK, 1'h1, 5000);
    check(n >= 3999 && n <= 4001, 1'h1);
    check(status.standby, 1'h1);
    // Bus stays quiet a full count of reference clocks past pin release
    repeat (BUS_GAP) step();
    check(status.standby, 1'h1);
  endtask

  task automatic stream_fmt(input logic [2:0] fmt);
    int act;
    int lo;
    act = (fmt == 3'h3 || fmt == 3'h4) ? 1000 : 3000;
    lo = FF + int'(fmt) * 100;
    fmt_sel <= fmt;
    exposure_lines <= {13'h0, fmt};
    stream_req <= 1'h1;
    step();
    stream_req <= 1'h0;
    wait_bit(SOF, 1'h1, 2000);
    check(n >= lo - 1 && n <= lo + 2, 1'h1);
    check(status.fps60, act == 1000);
    check(frame_size, size_tab[fmt]);
    // Standby asked mid-frame must not cut the frame short
    standby_req <= 1'h1;
    step();
    check(status.frame_active, 1'h1);
    wait_bit(STBY, 1'h1, 4000);
    check(n >= act - 4 && n <= act + 1, 1'h1);
    check(status.frame_active, 1'h0);
    check(status.streaming, 1'h0);
    standby_req <= 1'h0;
  endtask

  task automatic standby_now();
    stream_req <= 1'h1;
    step();
    stream_req <= 1'h0;
    step();
    check(status.streaming, 1'h1);
    standby_req <= 1'h1;
    wait_bit(STBY, 1'h1, 10);
    check(n <= 2, 1'h1);
    standby_req <= 1'h0;
  endtask

  task automatic standby_blank();
    stream_req <= 1'h1;
    step();
    stream_req <= 1'h0;
    wait_bit(SOF, 1'h1, 2000);
    wait_bit(ACT, 1'h0, 4000);
    check(status.streaming, 1'h1);
    // Blanking gap: no frame in flight, so standby is immediate
    standby_req <= 1'h1;
    wait_bit(STBY, 1'h1, 4);
    check(n, 1);
    check(status.streaming, 1'h0);
    standby_req <= 1'h0;
  endtask

  task automatic pin_reset();
    stream_req <= 1'h1;
    step();
    stream_req <= 1'h0;
    wait_bit(SOF, 1'h1, 2000);
    wait_bit(ACT, 1'h0, 4000);
    // Host keeps the pin up past the frame end before dropping it
    repeat (512) step();
    check(status.streaming, 1'h1);
    pwr_on <= 1'h0;
    wait_bit(INTR, 1'h1, 4);
    check(n, 2);
    check(status, 7'h40);
  endtask

  // ****************************************
  // Clock, sequence and watchdog
  // ****************************************
  initial begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end

  initial begin
    rst = 1'h1;
    pwr_on = 1'h0;
    stream_req = 1'h0;
    standby_req = 1'h0;
    fmt_sel = 3'h0;
    exposure_lines = 16'h0;
    err_total = 0;
    samples_checked = 0;
    repeat (5) @(posedge core_clk);
    rst <= 1'h0;
    step();
    power_up();
    for (int f = 0; f < 5; f++) begin
      stream_fmt(3'(f));
    end
    standby_now();
    standby_blank();
    pin_reset();
    tally_and_finish();
  end

  // Run needs about 70k cycles, most of it the 2 ms reset pulse
  initial begin
    repeat (90000) @(posedge core_clk);
    err_total++;
    tally_and_finish();
  end
endmodule // sensor_power_reset_sequencer_test

// ---- sensor_seq_pkg.sv ----
/*
  Constants, types and lookups shared by the sensor power and reset sequencer.
  Assumes a single 20 MHz core clock and supply-good levels already sampled in that domain.
*/
package sensor_seq_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned PLL_LOCK_NS = 200000;
  localparam int unsigned PLL_LOCK_CYCLES = PLL_LOCK_NS / CLK_PERIOD_NS;
  localparam int unsigned FIRST_FIXED_MS = 10;
  localparam int unsigned FIRST_FIXED_CYCLES = (FIRST_FIXED_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned FPS_LOW = 30;
  localparam int unsigned FPS_HIGH = 60;
  localparam int unsigned FRAME30_CYCLES = 1000000000 / FPS_LOW / CLK_PERIOD_NS;
  localparam int unsigned FRAME60_CYCLES = 1000000000 / FPS_HIGH / CLK_PERIOD_NS;
  localparam int unsigned LINE_CYCLES = 100;
  localparam int unsigned POR_CYCLES = 16;
  localparam logic [23:0] BLANK_CYCLES = 24'h0003E8;
  localparam int unsigned CNT_W = 24;

  // ****************************************
  // Output format
  // ****************************************
  localparam int unsigned PIXEL_BITS = 10;
  localparam int unsigned MIPI_LANES = 4;
  localparam int unsigned LANE_MBPS = 960;
  localparam logic [2:0] FMT_FULL = 3'h0;
  localparam logic [2:0] FMT_CROP_A = 3'h1;
  localparam logic [2:0] FMT_CROP_B = 3'h2;
  localparam logic [2:0] FMT_BIN_A = 3'h3;
  localparam logic [2:0] FMT_BIN_B = 3'h4;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_PLL = 3'b001,
    ST_STBY = 3'b010,
    ST_FIXW = 3'b011,
    ST_EXPW = 3'b100,
    ST_STRM = 3'b101,
    ST_STOP = 3'b110
  } seq_state_t;

  typedef struct packed {
    logic int_reset;
    logic pll_locked;
    logic standby;
    logic streaming;
    logic frame_active;
    logic frame_start;
    logic fps60;
  } seq_status_t;

  typedef struct packed {
    logic [11:0] width;
    logic [11:0] height;
  } frame_size_t;

  // Binned formats run at the higher frame rate
  function automatic logic fmt_binned(input logic [2:0] fmt);
    fmt_binned = (fmt == FMT_BIN_A) || (fmt == FMT_BIN_B);
  endfunction

  function automatic frame_size_t fmt_size(input logic [2:0] fmt);
    case (fmt)
      FMT_CROP_A: fmt_size = '{width: 12'hCC0, height: 12'h72C};
      FMT_CROP_B: fmt_size = '{width: 12'hB00, height: 12'h630};
      FMT_BIN_A: fmt_size = '{width: 12'h660, height: 12'h4C8};
      FMT_BIN_B: fmt_size = '{width: 12'h580, height: 12'h318};
      default: fmt_size = '{width: 12'hCC0, height: 12'h990};
    endcase
  endfunction

endpackage
